// [timer16_event_irq_regmap.sv]
`include "timer16_cfg.svh"
`default_nettype none

// What this block does
// RL1: With event counting and rising action, count once per event rising edge.
// RL2: With any-edge action, count on both rising and falling event edges.
// RL3: Gated action counts prescaled ticks while event high, holds while low.
// RL4: Direction action counts ticks up while event low, down while high.
// RL5: A two-bit action field in event control selects among four actions.
// RL6: Event action applies only when count-on-event bit is 1, else ticks.
// RL7: Split mode ignores all event-controlled counting.
// RL8: Normal mode flags overflow when counter wraps from top to zero.
// RL9: Normal mode flags each compare channel when counter equals its compare.
// RL10: Split mode flags low-byte underflow when low counter reaches bottom.
// RL11: Split mode flags high-byte underflow when high counter reaches bottom.
// RL12: Split mode flags compare channels on low-byte counter vs low compare byte.
// RL13: Every interrupt condition sets its flag regardless of enable.
// RL14: Each interrupt source has its own enable bit in the enable mask.
// RL15: A request is active exactly when enable and flag are both set.
// RL16: A request stays active until software clears the flag.
// RL17: All counting halts during sleep and resumes on wake.
// RL18: Three-bit prescale field divides clock by 1,2,4,8,16,64,256,1024.
// RL19: Writing one clears a flag bit; writing zero leaves it.
// RL20: 16-bit registers go low byte then high byte via the staging latch.
module timer16_event_irq_regmap
  import timer16_pkg::*;
(
  // Clock and reset
  input  wire  logic        clk_i,
  input  wire  logic        rst_i,
  // Wishbone slave
  input  wire  wb_req_s     wb_req_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  // Event input and system sleep
  input  wire  logic        event_i,
  input  wire  logic        sleep_i,
  // Interrupt requests per flag bit
  output logic [7:0]        irq_o
);

  // ========================================================================
  // Helpers
  function automatic logic [3:0] word_slot(input logic [5:0] idx);
    logic [3:0] s;
    s = `SLOT_NONE;
    case ({idx[5:1], 1'b0})
      `IDX_COUNT_VALUE:      s = `SLOT_CNT;
      `IDX_PERIOD_VALUE:     s = `SLOT_PER;
      `IDX_COMPARE_VALUE_0:  s = 4'd2;
      `IDX_COMPARE_VALUE_1:  s = 4'd3;
      `IDX_COMPARE_VALUE_2:  s = 4'd4;
      `IDX_PERIOD_BUFFER:    s = `SLOT_PERIOD_BUFFER;
      `IDX_COMPARE_BUFFER_0: s = 4'd6;
      `IDX_COMPARE_BUFFER_1: s = 4'd7;
      `IDX_COMPARE_BUFFER_2: s = 4'd8;
      default:               s = `SLOT_NONE;
    endcase
    return s;
  endfunction

  function automatic logic [9:0] presc_mask(input logic [2:0] code);
    logic [9:0] m;
    m = 10'h000;
    case (code)
      3'h0:    m = 10'h000;
      3'h1:    m = 10'h001;
      3'h2:    m = 10'h003;
      3'h3:    m = 10'h007;
      3'h4:    m = 10'h00f;
      3'h5:    m = 10'h03f;
      3'h6:    m = 10'h0ff;
      default: m = 10'h3ff;
    endcase
    return m;
  endfunction

  // ========================================================================
  // State
  timer_state_s s_ff;
  timer_state_s nxt_s;

  logic       run;
  logic       tick;
  logic [9:0] mask;
  logic [5:0] idx;
  logic [3:0] slot;
  logic       take;
  logic       fire;
  logic       ev_on;

  assign idx  = wb_req_i.adr[7:2];
  assign slot = word_slot(idx);
  assign take = wb_req_i.cyc && wb_req_i.stb && !s_ff.ack;
  assign fire = wb_req_i.cyc && wb_req_i.stb && s_ff.ack;
  assign run  = s_ff.timer_control_a[`BIT_ENABLE] && !sleep_i;                     // [RL17]
  assign mask = presc_mask(s_ff.timer_control_a[3:1]);
  assign tick = run && ((s_ff.presc & mask) == mask);                   // [RL18]
  assign ev_on = s_ff.event_input_control[`BIT_COUNT_ON_EVENT_ENABLE] && !s_ff.split_mode_enable;                // [RL6] [RL7]

  assign wb_ack_o = s_ff.ack;
  assign wb_dat_o = {24'h000000, s_ff.rdata};
  assign irq_o    = s_ff.flags & s_ff.irq_enable_mask;                          // [RL14] [RL15]

  // ========================================================================
  // Next state
  always_comb begin
    logic        step;
    logic        down;
    logic [15:0] cnt;
    logic [15:0] period_value;
    logic [15:0] word;
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [7:0]  set;
    logic [7:0]  clr;
    logic [7:0]  wd;
    step = 1'b0;
    down = 1'b0;
    cnt  = s_ff.wreg[`SLOT_CNT];
    period_value  = s_ff.wreg[`SLOT_PER];
    word = 16'h0000;
    lo   = 8'h00;
    hi   = 8'h00;
    set  = 8'h00;
    clr  = 8'h00;
    wd   = wb_req_i.dat[7:0];
    nxt_s = s_ff;
    nxt_s.ev_prev = event_i;

    // Prescaler restarts whenever the timer stops, so phase is known on start
    nxt_s.presc = run ? 10'(s_ff.presc + 10'h001) : 10'h000;            // [RL17]

    // ------------------------------------------------------------------
    // Counting
    if (s_ff.split_mode_enable) begin
      // Two down-counters; events have no say here
      if (tick) begin                                                   // [RL7]
        lo = cnt[7:0];
        hi = cnt[15:8];
        if (lo == 8'h00) begin
          lo = period_value[7:0];
          set[`BIT_OVF_LOW_BYTE_UNDERFLOW_IRQ] = 1'b1;                                    // [RL10]
        end else begin
          lo = 8'(lo - 8'h01);
        end
        if (hi == 8'h00) begin
          hi = period_value[15:8];
          set[`BIT_HIGH_BYTE_UNDERFLOW_IRQ] = 1'b1;                                        // [RL11]
        end else begin
          hi = 8'(hi - 8'h01);
        end
        cnt = {hi, lo};
        for (int i = 0; i < 3; i++) begin
          if (lo == s_ff.wreg[4'(i + 2)][7:0]) begin
            set[`BIT_CMP_BASE + i] = 1'b1;                              // [RL12]
          end
        end
      end
    end else begin
      if (ev_on) begin
        case (ev_action_e'(s_ff.event_input_control[2:1]))                           // [RL5]
          ev_rise: step = run && event_i && !s_ff.ev_prev;              // [RL1]
          ev_any:  step = run && (event_i != s_ff.ev_prev);             // [RL2]
          ev_gate: step = tick && event_i;                              // [RL3]
          ev_dir: begin
            step = tick;
            down = event_i;                                             // [RL4]
          end
          default: step = 1'b0;
        endcase
      end else begin
        step = tick;                                                    // [RL6]
        down = s_ff.dir;
      end
      if (step) begin
        if (!down && cnt == period_value) begin
          cnt = 16'h0000;
          set[`BIT_OVF_LOW_BYTE_UNDERFLOW_IRQ] = 1'b1;                                    // [RL8]
        end else if (down && cnt == 16'h0000) begin
          cnt = period_value;
          set[`BIT_OVF_LOW_BYTE_UNDERFLOW_IRQ] = 1'b1;
        end else if (down) begin
          cnt = 16'(cnt - 16'h0001);
        end else begin
          cnt = 16'(cnt + 16'h0001);
        end
        for (int i = 0; i < 3; i++) begin
          if (cnt == s_ff.wreg[4'(i + 2)]) begin
            set[`BIT_CMP_BASE + i] = 1'b1;                              // [RL9]
          end
        end
      end
    end
    nxt_s.wreg[`SLOT_CNT] = cnt;

    // ------------------------------------------------------------------
    // Bus: read data captured on take, effects land on the ack edge
    nxt_s.ack = take;
    if (take) begin
      nxt_s.rdata = 8'h00;
      if (slot != `SLOT_NONE) begin
        word = s_ff.wreg[slot];
        nxt_s.rdata = idx[0] ? s_ff.temp : word[7:0];                   // [RL20]
      end else begin
        case (idx)
          `IDX_TIMER_CONTROL_A:        nxt_s.rdata = s_ff.timer_control_a;
          `IDX_TIMER_CONTROL_B:        nxt_s.rdata = s_ff.timer_control_b;
          `IDX_OUTPUT_VALUE_CONTROL:   nxt_s.rdata = s_ff.output_value_control;
          `IDX_SPLIT_SELECT_CONTROL:   nxt_s.rdata = {7'h00, s_ff.split_mode_enable};
          `IDX_COMMAND_LOCK_DIR_CLEAR,
          `IDX_COMMAND_LOCK_DIR_SET:   nxt_s.rdata = {6'h00, s_ff.lupd, s_ff.dir};
          `IDX_BUFFER_VALID_CLEAR,
          `IDX_BUFFER_VALID_SET:       nxt_s.rdata = {4'h0, s_ff.bv};
          `IDX_EVENT_INPUT_CONTROL:    nxt_s.rdata = {5'h00, s_ff.event_input_control};
          `IDX_IRQ_ENABLE_MASK:        nxt_s.rdata = s_ff.irq_enable_mask;
          `IDX_IRQ_PENDING_FLAGS:      nxt_s.rdata = s_ff.flags;
          `IDX_DEBUG_RUN_CONTROL:      nxt_s.rdata = {7'h00, s_ff.dbgrun};
          `IDX_BYTE_STAGING_LATCH:     nxt_s.rdata = s_ff.temp;
          default:                     nxt_s.rdata = 8'h00;
        endcase
      end
    end

    if (fire && !wb_req_i.we && slot != `SLOT_NONE && !idx[0]) begin
      word = s_ff.wreg[slot];
      nxt_s.temp = word[15:8];                                          // [RL20]
    end

    if (fire && wb_req_i.we && wb_req_i.sel[0]) begin
      if (slot != `SLOT_NONE) begin
        if (idx[0]) begin
          nxt_s.wreg[slot] = {wd, s_ff.temp};                           // [RL20]
        end else begin
          nxt_s.temp = wd;
        end
      end else begin
        case (idx)
          `IDX_TIMER_CONTROL_A:        nxt_s.timer_control_a = {4'h0, wd[3:0]};
          `IDX_TIMER_CONTROL_B:        nxt_s.timer_control_b = {1'b0, wd[6:0]};
          `IDX_OUTPUT_VALUE_CONTROL:   nxt_s.output_value_control = {5'h00, wd[2:0]};
          `IDX_SPLIT_SELECT_CONTROL:   nxt_s.split_mode_enable = wd[`BIT_SPLIT_MODE_ENABLE];
          `IDX_COMMAND_LOCK_DIR_CLEAR: begin
            nxt_s.lupd = s_ff.lupd && !wd[`BIT_LUPD];
            nxt_s.dir  = s_ff.dir && !wd[`BIT_DIR];
          end
          `IDX_COMMAND_LOCK_DIR_SET: begin
            nxt_s.lupd = s_ff.lupd || wd[`BIT_LUPD];
            nxt_s.dir  = s_ff.dir || wd[`BIT_DIR];
          end
          `IDX_BUFFER_VALID_CLEAR:     nxt_s.bv = s_ff.bv & ~wd[3:0];
          `IDX_BUFFER_VALID_SET:       nxt_s.bv = s_ff.bv | wd[3:0];
          `IDX_EVENT_INPUT_CONTROL:    nxt_s.event_input_control = wd[2:0];
          `IDX_IRQ_ENABLE_MASK:        nxt_s.irq_enable_mask = wd & 8'h73;      // [RL14]
          `IDX_IRQ_PENDING_FLAGS:      clr = wd;                        // [RL19]
          `IDX_DEBUG_RUN_CONTROL:      nxt_s.dbgrun = wd[0];
          `IDX_BYTE_STAGING_LATCH:     nxt_s.temp = wd;
          default:                     nxt_s.temp = s_ff.temp;
        endcase
      end
    end

    // A new event beats a clear in the same cycle; flags ignore the mask
    nxt_s.flags = (s_ff.flags & ~clr) | set;                            // [RL13] [RL16] [RL19]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '0;
      s_ff.wreg[`SLOT_PER] <= `RST_PERIOD;
      s_ff.wreg[`SLOT_PERIOD_BUFFER] <= `RST_PERIOD;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ========================================================================
  // Assertions
  a_rise_count: assert property ( // [RL1]
    @(posedge clk_i) disable iff (rst_i)
    (!s_ff.split_mode_enable && ev_on && s_ff.event_input_control[2:1] == 2'h0 && run && event_i
     && !s_ff.ev_prev && !wb_req_i.cyc && s_ff.wreg[`SLOT_CNT] != s_ff.wreg[`SLOT_PER])
    |=> s_ff.wreg[`SLOT_CNT] == 16'($past(s_ff.wreg[`SLOT_CNT]) + 16'h0001))
    else $error("rising event did not advance counter");

  a_fall_count: assert property ( // [RL2]
    @(posedge clk_i) disable iff (rst_i)
    (ev_on && s_ff.event_input_control[2:1] == 2'h1 && run && !event_i && s_ff.ev_prev
     && !wb_req_i.cyc && s_ff.wreg[`SLOT_CNT] != s_ff.wreg[`SLOT_PER])
    |=> s_ff.wreg[`SLOT_CNT] == 16'($past(s_ff.wreg[`SLOT_CNT]) + 16'h0001))
    else $error("falling event not counted in any-edge action");

  a_gate_hold: assert property ( // [RL3]
    @(posedge clk_i) disable iff (rst_i)
    (ev_on && s_ff.event_input_control[2:1] == 2'h2 && !event_i && !wb_req_i.cyc)
    |=> $stable(s_ff.wreg[`SLOT_CNT]))
    else $error("gated count moved while event low");

  a_dir_down: assert property ( // [RL4]
    @(posedge clk_i) disable iff (rst_i)
    (ev_on && s_ff.event_input_control[2:1] == 2'h3 && event_i && tick && !wb_req_i.cyc
     && s_ff.wreg[`SLOT_CNT] != 16'h0000)
    |=> s_ff.wreg[`SLOT_CNT] == 16'($past(s_ff.wreg[`SLOT_CNT]) - 16'h0001))
    else $error("direction action did not count down");

  a_split_noevent: assert property ( // [RL7]
    @(posedge clk_i) disable iff (rst_i)
    (s_ff.split_mode_enable && !tick && !wb_req_i.cyc) |=> $stable(s_ff.wreg[`SLOT_CNT]))
    else $error("split counter moved without a tick");

  a_wrap_ovf: assert property ( // [RL8]
    @(posedge clk_i) disable iff (rst_i)
    (!s_ff.split_mode_enable && !ev_on && !s_ff.dir && tick && !(fire && wb_req_i.we)
     && s_ff.wreg[`SLOT_CNT] == s_ff.wreg[`SLOT_PER])
    |=> s_ff.wreg[`SLOT_CNT] == 16'h0000 && s_ff.flags[`BIT_OVF_LOW_BYTE_UNDERFLOW_IRQ])
    else $error("wrap at top did not zero counter and flag overflow");

  a_flag_sticky: assert property ( // [RL16]
    @(posedge clk_i) disable iff (rst_i)
    (irq_o[`BIT_OVF_LOW_BYTE_UNDERFLOW_IRQ] && !wb_req_i.cyc) |=> irq_o[`BIT_OVF_LOW_BYTE_UNDERFLOW_IRQ]) 
    else $error("request dropped without a flag clear");

  a_sleep_halt: assert property ( // [RL17]
    @(posedge clk_i) disable iff (rst_i)
    (sleep_i && !wb_req_i.cyc) |=> $stable(s_ff.wreg[`SLOT_CNT]) && s_ff.presc == 10'h000)
    else $error("timer ran during sleep");

  // Only a software write to the counter may override the reload
  a_lo_underflow: assert property ( // [RL10]
    @(posedge clk_i) disable iff (rst_i)
    (s_ff.split_mode_enable && tick && s_ff.wreg[`SLOT_CNT][7:0] == 8'h00 && !(fire && wb_req_i.we))
    |=> s_ff.flags[`BIT_OVF_LOW_BYTE_UNDERFLOW_IRQ]
        && s_ff.wreg[`SLOT_CNT][7:0] == $past(s_ff.wreg[`SLOT_PER][7:0]))
    else $error("low byte did not reload and flag underflow");

  a_hi_underflow: assert property ( // [RL11]
    @(posedge clk_i) disable iff (rst_i)
    (s_ff.split_mode_enable && tick && s_ff.wreg[`SLOT_CNT][15:8] == 8'h00 && !(fire && wb_req_i.we))
    |=> s_ff.flags[`BIT_HIGH_BYTE_UNDERFLOW_IRQ]
        && s_ff.wreg[`SLOT_CNT][15:8] == $past(s_ff.wreg[`SLOT_PER][15:8]))
    else $error("high byte did not reload and flag underflow");

endmodule

`default_nettype wire

// [timer16_cfg.svh]
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define IDX_TIMER_CONTROL_A        6'h00
`define IDX_TIMER_CONTROL_B        6'h01
`define IDX_OUTPUT_VALUE_CONTROL   6'h02
`define IDX_SPLIT_SELECT_CONTROL   6'h03
`define IDX_COMMAND_LOCK_DIR_CLEAR 6'h04
`define IDX_COMMAND_LOCK_DIR_SET   6'h05
`define IDX_BUFFER_VALID_CLEAR     6'h06
`define IDX_BUFFER_VALID_SET       6'h07
`define IDX_EVENT_INPUT_CONTROL    6'h09
`define IDX_IRQ_ENABLE_MASK        6'h0a
`define IDX_IRQ_PENDING_FLAGS      6'h0b
`define IDX_DEBUG_RUN_CONTROL      6'h0e
`define IDX_BYTE_STAGING_LATCH     6'h0f
`define IDX_COUNT_VALUE            6'h20
`define IDX_PERIOD_VALUE           6'h26
`define IDX_COMPARE_VALUE_0        6'h28
`define IDX_COMPARE_VALUE_1        6'h2a
`define IDX_COMPARE_VALUE_2        6'h2c
`define IDX_PERIOD_BUFFER          6'h36
`define IDX_COMPARE_BUFFER_0       6'h38
`define IDX_COMPARE_BUFFER_1       6'h3a
`define IDX_COMPARE_BUFFER_2       6'h3c

// ==========================================================================
// Slots of the 16-bit register array
`define SLOT_CNT     4'd0
`define SLOT_PER     4'd1
`define SLOT_COMPARE_CHANNEL_0_IRQ    4'd2
`define SLOT_PERIOD_BUFFER  4'd5
`define SLOT_CMPBUF0 4'd6
`define SLOT_NONE    4'hf

// ==========================================================================
// Field positions
`define BIT_ENABLE      0
`define BIT_COUNT_ON_EVENT_ENABLE       0
`define BIT_SPLIT_MODE_ENABLE      0
`define BIT_DIR         0
`define BIT_LUPD        1
`define BIT_OVF_LOW_BYTE_UNDERFLOW_IRQ    0
`define BIT_HIGH_BYTE_UNDERFLOW_IRQ        1
`define BIT_CMP_BASE    4

// ==========================================================================
// Reset values
`define RST_BYTE        8'h00
`define RST_PERIOD      16'hffff

`endif

// [timer16_pkg.sv]
`default_nettype none

package timer16_pkg;

  // ========================================================================
  // Wishbone request bundle
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;

  // ========================================================================
  // Event action field codes, in field order
  typedef enum logic [1:0] {
    ev_rise,
    ev_any,
    ev_gate,
    ev_dir
  } ev_action_e;

  // ========================================================================
  // Whole state of the timer
  typedef struct packed {
    logic             ack;
    logic [7:0]       rdata;
    logic [7:0]       timer_control_a;
    logic [7:0]       timer_control_b;
    logic [7:0]       output_value_control;
    logic             split_mode_enable;
    logic             lupd;
    logic             dir;
    logic [3:0]       bv;
    logic [2:0]       event_input_control;
    logic [7:0]       irq_enable_mask;
    logic [7:0]       flags;
    logic             dbgrun;
    logic [7:0]       temp;
    logic [8:0][15:0] wreg;
    logic [9:0]       presc;
    logic             ev_prev;
  } timer_state_s;

endpackage

`default_nettype wire

// [event_route_model.sv]
`default_nettype none

// ==========================================================================
// Event routing source and interrupt controller seen from the timer
module event_route_model (
  // Clock
  input  wire logic       clk_i,
  // Interrupt lines from the timer
  input  wire logic [7:0] irq_i,
  // Routed event and vectors taken
  output var  logic       event_o,
  output var  logic [7:0] served_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial event_o = 1'h0;
  initial served_o = 8'h00;

  // Takes every raised vector but never clears a flag itself
  always @(posedge clk_i) begin
    if (irq_i !== 8'h00) begin
      served_o <= irq_i;
    end
  end

  // Event level changes only just after an edge, like on-chip routing
  task automatic level(input logic v, input int n);
    event_o <= v;
    repeat (n) @(posedge clk_i);
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      level(1'h1, 2);
      level(1'h0, 2);
    end
  endtask
endmodule

`default_nettype wire

// [tb_timer16_event_irq_regmap.sv]
`include "timer16_cfg.svh"
`default_nettype none

module tb_timer16_event_irq_regmap
  import timer16_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ========================================================================
  // Signals
  typedef struct {
    string      name;
    logic [1:0] kind;
    logic [7:0] val;
  } note_s;

  localparam logic [5:0] ctrl_ix  = `IDX_TIMER_CONTROL_A;
  localparam logic [5:0] split_ix = `IDX_SPLIT_SELECT_CONTROL;
  localparam logic [5:0] ev_ix    = `IDX_EVENT_INPUT_CONTROL;
  localparam logic [5:0] mask_ix  = `IDX_IRQ_ENABLE_MASK;
  localparam logic [5:0] flag_ix  = `IDX_IRQ_PENDING_FLAGS;
  localparam logic [5:0] cnt_ix   = `IDX_COUNT_VALUE;
  localparam logic [5:0] per_ix   = `IDX_PERIOD_VALUE;

  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        sleep_i = 1'h0;
  logic        event_w;
  wb_req_s     req = '0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [7:0]  irq_o;
  logic [7:0]  served;
  note_s       note_q[$];
  note_s       nt;
  logic [7:0]  last_seen = 8'h00;
  int          err_total = 0;
  int          checks_done = 0;
  int          n;
  int          divs[8] = '{1, 2, 4, 8, 16, 64, 256, 1024};

  always #50 clk_i = ~clk_i;

  timer16_event_irq_regmap i_timer16_event_irq_regmap (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_req_i (req),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .event_i  (event_w),
    .sleep_i  (sleep_i),
    .irq_o    (irq_o)
  );

  event_route_model i_event_route_model (
    .clk_i    (clk_i),
    .irq_i    (irq_o),
    .event_o  (event_w),
    .served_o (served)
  );

  // ========================================================================
  // Checking and bus tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Called just after an edge; holds the request until ack is sampled
  // No wait is assumed; only the watchdog ends a hung request
  task automatic bus(input logic w, input logic [5:0] ix, input logic [7:0] d);
    req <= {1'h1, 1'h1, w, {ix, 2'h0}, 4'hf, {24'h000000, d}};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'h1);
    req <= '0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [5:0] ix, input logic [7:0] d);
    bus(1'h1, ix, d);
  endtask

  // Kind 0 absolute, 1 delta from previous read, 2 reference only
  task automatic rd(input logic [5:0] ix, input logic [1:0] k, input logic [7:0] v,
                    input string nm);
    note_q.push_back('{nm, k, v});
    bus(1'h0, ix, 8'h00);
  endtask

  function automatic logic [7:0] evc(input ev_action_e a);
    return {5'h00, a, 1'h1};
  endfunction

  always @(posedge clk_i) begin
    if (wb_ack_o === 1'h1 && req.we === 1'h0) begin
      if (note_q.size() == 0) begin
        chk("read_note", 32'h1, 32'h0);
      end else begin
        nt = note_q.pop_front();
        if (nt.kind == 2'h0) chk(nt.name, {24'h000000, nt.val}, wb_dat_o);
        if (nt.kind == 2'h1) chk(nt.name, {24'h000000, 8'(last_seen + nt.val)}, wb_dat_o);
        last_seen = wb_dat_o[7:0];
      end
    end
  end

  // Longest run is the prescale sweep, about 11000 cycles
  initial begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    $display("Error watchdog expected done seen timeout");
    test_done();
  end

  // ========================================================================
  // Scenarios
  initial begin
    void'($urandom(3));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    chk("irq_o", 32'h0, {24'h000000, irq_o});
    rd(ctrl_ix, 2'h0, 8'h00, "timer_control_a");
    rd(per_ix, 2'h0, 8'hff, "period_value");
    wr(6'h08, 8'hff);
    rd(6'h08, 2'h0, 8'h00, "unmapped");
    // Eight ticks over eight divided periods, whatever the phase
    for (int c = 0; c < 8; c++) begin
      wr(ctrl_ix, {4'h0, 3'(c), 1'h1});
      rd(cnt_ix, 2'h2, 8'h00, "");
      repeat (8 * divs[c] - 3) @(posedge clk_i);
      rd(cnt_ix, 2'h1, 8'h08, "count_value");
    end
    wr(ctrl_ix, 8'h01);
    n = $urandom_range(20, 1);
    wr(ev_ix, evc(ev_rise));
    rd(cnt_ix, 2'h2, 8'h00, "");
    i_event_route_model.pulses(n);
    i_event_route_model.level(1'h0, 2);
    rd(cnt_ix, 2'h1, 8'(n), "count_value");
    wr(ev_ix, evc(ev_any));
    rd(cnt_ix, 2'h2, 8'h00, "");
    i_event_route_model.pulses(n);
    i_event_route_model.level(1'h0, 2);
    rd(cnt_ix, 2'h1, 8'(2 * n), "count_value");
    n = $urandom_range(40, 5);
    wr(ev_ix, evc(ev_gate));
    rd(cnt_ix, 2'h2, 8'h00, "");
    i_event_route_model.level(1'h1, n);
    i_event_route_model.level(1'h0, 3);
    rd(cnt_ix, 2'h1, 8'(n), "count_value");
    // Window is n+6 ticks, n of them downward
    wr(ev_ix, evc(ev_dir));
    rd(cnt_ix, 2'h2, 8'h00, "");
    i_event_route_model.level(1'h1, n);
    i_event_route_model.level(1'h0, 3);
    rd(cnt_ix, 2'h1, 8'(6 - n), "count_value");
    // Gated with event low would hold; split mode must still count down
    wr(ev_ix, evc(ev_gate));
    wr(split_ix, 8'h01);
    rd(cnt_ix, 2'h2, 8'h00, "");
    repeat (20) @(posedge clk_i);
    rd(cnt_ix, 2'h1, 8'he9, "count_value");
    wr(split_ix, 8'h00);
    wr(ev_ix, 8'h00);
    sleep_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rd(cnt_ix, 2'h2, 8'h00, "");
    repeat (10) @(posedge clk_i);
    rd(cnt_ix, 2'h1, 8'h00, "count_value");
    sleep_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    rd(cnt_ix, 2'h2, 8'h00, "");
    repeat (10) @(posedge clk_i);
    rd(cnt_ix, 2'h1, 8'h0d, "count_value");
    wr(ctrl_ix, 8'h00);
    wr(flag_ix, 8'hff);
    rd(flag_ix, 2'h0, 8'h00, "irq_pending_flags");
    wr(cnt_ix, 8'hfe);
    wr(cnt_ix + 6'h01, 8'hff);
    rd(cnt_ix, 2'h0, 8'hfe, "count_value");
    rd(cnt_ix + 6'h01, 2'h0, 8'hff, "count_value_high");
    // A few ticks across the wrap; compares all sit at zero
    wr(ctrl_ix, 8'h01);
    wr(ctrl_ix, 8'h00);
    rd(flag_ix, 2'h0, 8'h71, "irq_pending_flags");
    chk("irq_o", 32'h0, {24'h000000, irq_o});
    wr(mask_ix, 8'hff);
    rd(mask_ix, 2'h0, 8'h73, "irq_enable_mask");
    chk("irq_o", 32'h71, {24'h000000, irq_o});
    repeat (8) @(posedge clk_i);
    chk("served", 32'h71, {24'h000000, served});
    chk("irq_o", 32'h71, {24'h000000, irq_o});
    wr(flag_ix, 8'h00);
    rd(flag_ix, 2'h0, 8'h71, "irq_pending_flags");
    wr(flag_ix, 8'h11);
    rd(flag_ix, 2'h0, 8'h60, "irq_pending_flags");
    wr(mask_ix, 8'h20);
    chk("irq_o", 32'h20, {24'h000000, irq_o});
    // Split bytes from 0x0101 over three ticks: match at zero, then both reload
    wr(flag_ix, 8'hff);
    wr(cnt_ix, 8'h01);
    wr(cnt_ix + 6'h01, 8'h01);
    wr(split_ix, 8'h01);
    wr(ctrl_ix, 8'h01);
    wr(ctrl_ix, 8'h00);
    rd(flag_ix, 2'h0, 8'h73, "irq_pending_flags");
    rd(cnt_ix, 2'h0, 8'hfe, "count_value");
    chk("irq_o", 32'h20, {24'h000000, irq_o});
    // Direction bit set: three ticks downward from 0xfefe
    wr(split_ix, 8'h00);
    wr(`IDX_COMMAND_LOCK_DIR_SET, 8'h01);
    wr(ctrl_ix, 8'h01);
    wr(ctrl_ix, 8'h00);
    rd(cnt_ix, 2'h0, 8'hfb, "count_value");
    test_done();
  end
endmodule

`default_nettype wire
